// ---- inc/sla_map.svh ----
// Operation
// RULE1 - Clearing link reset bit releases link reset and starts synchronization.
// RULE2 - Setting link reset bit disables the link and holds it in reset.
// RULE3 - Every lane carries a FIFO between framer and serializer.
// RULE4 - Programmable write phase against read side improves FIFO pointer margin.
// RULE5 - Quick configuration selects M, L, F; S is always one.
// RULE6 - High density flag reads one only for one converter, two lanes.
// RULE7 - Config bit 0 enables SYSREF buffer; resets to zero.
// RULE8 - Software enables buffer alone first, then writes remaining bits.
// RULE9 - With buffer disabled, external SYSREF reaches no internal logic.
// RULE10 - One-shot: software disables buffer after SYSREF captured.
// RULE11 - Continuous SYSREF: software leaves buffer enabled.
// RULE12 - Config bit 1 enables SYSREF users; gated SYSREF still reaches others.
// RULE13 - In one-shot mode the SYSREF enable bit clears itself after event.
// RULE14 - Config bit 2 selects continuous (0) or one-shot (1) SYSREF.
// RULE15 - Config bit 3: active SYSREF realigns clocks and resets the link.
// RULE16 - Software uses realign on SYSREF only one-shot, before first link.
// RULE17 - Continuous mode: software keeps realign-on-SYSREF at zero.
// RULE18 - Config bit 4: sync low four multiframe periods forces realignment.
// RULE19 - Scrambling off: repeated last octet becomes K28.7, or K28.3 at multiframe end.
// RULE20 - Scrambling on: last octet D28.7 not at multiframe end becomes K28.7.
// RULE21 - Scrambling and lane sync on: D28.3 at multiframe end becomes K28.3.
// RULE22 - Lane sync off: replacements always use K28.7.
// RULE23 - Scrambling enabled by default, bit 7; active only after lane sync.
// RULE24 - Replacement applies only to user data after the alignment sequence.
`ifndef SLA_MAP_SVH
`define SLA_MAP_SVH
`define SLA_OFS_SYSREF_CFG 8'h3A
`define SLA_OFS_QUICK_CFG 8'h5E
`define SLA_OFS_LINK_CTRL 8'h5F
`define SLA_OFS_LANE_SCR 8'h6E
`define SLA_OFS_OCT_FRAME 8'h6F
`define SLA_OFS_CONV_CNT 8'h71
`define SLA_OFS_SAMP_FRAME 8'h74
`define SLA_OFS_HD_FLAG 8'h75
`define SLA_OFS_WR_PHASE 8'hEE
`define SLA_OFS_RD_MARGIN 8'hEF
`define SLA_OFS_LINK_STAT 8'h90
`define SLA_RST_SYSREF_CFG 8'h00
`define SLA_RST_QUICK_CFG 8'h22
`define SLA_RST_LINK_CTRL 8'h10
`define SLA_RST_SCR 1'h1
`define SLA_RST_WR_PHASE 8'h00
`define SLA_RST_RD_MARGIN 8'h02
`define SLA_BIT_BUF_EN 0
`define SLA_BIT_SR_EN 1
`define SLA_BIT_SR_MODE 2
`define SLA_BIT_RA_SR 3
`define SLA_BIT_RA_SYNC 4
`define SLA_BIT_LINK_RST 0
`define SLA_BIT_LANE_SYNC 4
`define SLA_BIT_SCR 7
`define SLA_QC_1C1L 8'h11
`define SLA_QC_1C2L 8'h12
`define SLA_QC_2C1L 8'h21
`define SLA_QC_2C2L 8'h22
`define SLA_CHR_28_7 8'hFC
`define SLA_CHR_28_3 8'h7C
`define SLA_SYNC_LMFC_MIN 3'h4
`define SLA_FIFO_DEPTH 8
`endif

// ---- inc/sla_pkg.sv ----
`default_nettype none
package sla_pkg;
   typedef enum logic [3:0] {
      SLA_ST_RESET = 4'b0001,
      SLA_ST_SYNC = 4'b0010,
      SLA_ST_ILAS = 4'b0100,
      SLA_ST_DATA = 4'b1000
   } sla_state_e;
endpackage : sla_pkg
`default_nettype wire

// ---- logic/sla_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module sla_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   // depth must be a power of two for the wrap arithmetic
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp;
   logic [AW:0] rp;
   wire do_wr = in_valid & in_ready;
   wire do_rd = out_valid & out_ready;
   assign level = wp - rp;
   assign in_ready = (level != (AW+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data = mem[rp[AW-1:0]];
   always_ff @(posedge sys_clk) begin
      if (rst | clr) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (do_wr) wp <= wp + 1'b1;
         if (do_rd) rp <= rp + 1'b1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (do_wr) mem[wp[AW-1:0]] <= in_data;
   end
endmodule : sla_fifo
`default_nettype wire

// ---- logic/sla_sync_detect.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sla_map.svh"
module sla_sync_detect (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic sync_request_low,
   input wire logic lmfc_tick,
   output logic sync_active
);
   logic [2:0] cnt;
   wire req = ~sync_request_low;
   wire reach = req & lmfc_tick & (cnt == `SLA_SYNC_LMFC_MIN - 3'h1); // RULE18
   wire [2:0] next_cnt = ~req ? 3'h0 :
                         (lmfc_tick & (cnt != `SLA_SYNC_LMFC_MIN)) ? cnt + 3'h1 : cnt;
   // one pulse per low stretch; count saturates so a long low does not retrigger
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt <= 3'h0;
         sync_active <= 1'b0;
      end else begin
         cnt <= next_cnt;
         sync_active <= reach;
      end
   end
endmodule : sla_sync_detect
`default_nettype wire

// ---- logic/sla_link_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sla_map.svh"
module sla_link_ctrl (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   input wire logic sysref,
   input wire logic sync_request_low,
   input wire logic lmfc_tick,
   input wire logic [15:0] fr_data,
   input wire logic [1:0] fr_valid,
   output logic [1:0] fr_ready,
   input wire logic [1:0] fr_frame_end,
   input wire logic [1:0] fr_mf_end,
   input wire logic fr_ilas,
   output logic [15:0] ser_data,
   output logic [1:0] ser_k,
   output logic [1:0] ser_valid,
   input wire logic [1:0] ser_ready,
   output logic link_rst,
   output logic link_up,
   output logic scr_active,
   output logic sysref_int,
   output logic sysref_capture,
   output logic clk_realign
);

////////////////////////////////////////////////////////////////////////////////
// registers

   logic [7:0] sysref_cfg;
   logic [7:0] quick_cfg;
   logic [7:0] link_ctrl;
   logic scr_en;
   logic [7:0] wr_phase;
   logic [7:0] rd_margin;

   sla_pkg::sla_state_e state;
   sla_pkg::sla_state_e next_state;

   wire wr_sysref = reg_we & (reg_addr == `SLA_OFS_SYSREF_CFG);
   wire wr_quick = reg_we & (reg_addr == `SLA_OFS_QUICK_CFG);
   wire wr_link = reg_we & (reg_addr == `SLA_OFS_LINK_CTRL);
   wire wr_scr = reg_we & (reg_addr == `SLA_OFS_LANE_SCR);
   wire wr_phase_sel = reg_we & (reg_addr == `SLA_OFS_WR_PHASE);
   wire wr_margin = reg_we & (reg_addr == `SLA_OFS_RD_MARGIN);

   // unknown settings are dropped so the derived parameters stay consistent
   wire qc_ok = (reg_wdata == `SLA_QC_1C1L) | (reg_wdata == `SLA_QC_1C2L) |
                (reg_wdata == `SLA_QC_2C1L) | (reg_wdata == `SLA_QC_2C2L);

////////////////////////////////////////////////////////////////////////////////
// derived link parameters

   wire [7:0] par_m = (quick_cfg[7:4] == 4'h1) ? 8'h01 : 8'h02; // RULE5
   wire lanes_m1 = (quick_cfg[3:0] == 4'h2); // RULE5
   wire [7:0] par_f = (quick_cfg == `SLA_QC_1C2L) ? 8'h01 :
                      (quick_cfg == `SLA_QC_2C1L) ? 8'h04 : 8'h02; // RULE5
   wire [4:0] par_s = 5'h01; // RULE5
   wire hd_flag = (quick_cfg == `SLA_QC_1C2L); // RULE6
   wire [1:0] lane_on = {lanes_m1, 1'b1};

////////////////////////////////////////////////////////////////////////////////
// sysref handling

   logic sysref_d;
   wire buf_en = sysref_cfg[`SLA_BIT_BUF_EN];
   wire sr_en = sysref_cfg[`SLA_BIT_SR_EN];
   wire sr_oneshot = sysref_cfg[`SLA_BIT_SR_MODE];
   wire sysref_gated = sysref & buf_en; // RULE7 RULE9
   wire sysref_rise = sysref_gated & ~sysref_d;
   wire sysref_hit = sysref_rise & sr_en; // RULE12
   wire sync_active;
   wire ra_sysref = sysref_hit & sysref_cfg[`SLA_BIT_RA_SR]; // RULE15
   wire ra_sync = sync_active & sysref_cfg[`SLA_BIT_RA_SYNC]; // RULE18
   wire realign = ra_sysref | ra_sync;
   wire self_clr = sysref_hit & sr_oneshot; // RULE13 RULE14

   // a software write in the same cycle wins: it is the newer intent
   wire [7:0] next_sysref_cfg = wr_sysref ? {3'h0, reg_wdata[4:0]} :
                                self_clr ? (sysref_cfg & ~(8'h01 << `SLA_BIT_SR_EN)) :
                                sysref_cfg;

   sla_sync_detect u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .sync_request_low(sync_request_low),
      .lmfc_tick(lmfc_tick),
      .sync_active(sync_active)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sysref_d <= 1'b0;
         sysref_cfg <= `SLA_RST_SYSREF_CFG; // RULE7
         sysref_capture <= 1'b0;
         clk_realign <= 1'b0;
      end else begin
         sysref_d <= sysref_gated;
         sysref_cfg <= next_sysref_cfg; // RULE13
         sysref_capture <= sysref_hit;
         clk_realign <= realign; // RULE15 RULE18
      end
   end

   // gated sysref still feeds circuits that ignore the enable bit
   assign sysref_int = sysref_gated; // RULE12

////////////////////////////////////////////////////////////////////////////////
// configuration registers

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         quick_cfg <= `SLA_RST_QUICK_CFG;
         link_ctrl <= `SLA_RST_LINK_CTRL;
         scr_en <= `SLA_RST_SCR; // RULE23
         wr_phase <= `SLA_RST_WR_PHASE;
         rd_margin <= `SLA_RST_RD_MARGIN;
      end else begin
         if (wr_quick & qc_ok) quick_cfg <= reg_wdata; // RULE5
         if (wr_link) link_ctrl <= reg_wdata & 8'h11;
         if (wr_scr) scr_en <= reg_wdata[`SLA_BIT_SCR]; // RULE23
         if (wr_phase_sel) wr_phase <= reg_wdata;
         if (wr_margin) rd_margin <= {4'h0, reg_wdata[3:0]};
      end
   end

////////////////////////////////////////////////////////////////////////////////
// link state

   wire hold_rst = link_ctrl[`SLA_BIT_LINK_RST]; // RULE2
   wire lane_sync = link_ctrl[`SLA_BIT_LANE_SYNC];

   always_comb begin
      next_state = state;
      case (state)
         sla_pkg::SLA_ST_RESET: begin
            if (!hold_rst) next_state = sla_pkg::SLA_ST_SYNC; // RULE1
         end
         sla_pkg::SLA_ST_SYNC: begin
            if (sync_request_low) next_state = sla_pkg::SLA_ST_ILAS;
         end
         sla_pkg::SLA_ST_ILAS: begin
            if (!sync_request_low) next_state = sla_pkg::SLA_ST_SYNC;
            else if (!fr_ilas) next_state = sla_pkg::SLA_ST_DATA;
         end
         sla_pkg::SLA_ST_DATA: begin
            if (!sync_request_low) next_state = sla_pkg::SLA_ST_SYNC;
         end
         default: begin
            next_state = sla_pkg::SLA_ST_RESET;
         end
      endcase
      // a realign pulls the link back through reset for at least one cycle
      if (hold_rst | realign) next_state = sla_pkg::SLA_ST_RESET; // RULE2 RULE15
   end

   always_ff @(posedge sys_clk) begin
      if (rst) state <= sla_pkg::SLA_ST_RESET;
      else state <= next_state;
   end

   wire in_reset = (state == sla_pkg::SLA_ST_RESET);
   wire in_data = (state == sla_pkg::SLA_ST_DATA);
   assign link_rst = in_reset; // RULE2
   assign link_up = in_data;
   assign scr_active = scr_en & in_data; // RULE23

////////////////////////////////////////////////////////////////////////////////
// fifo write phase and read margin

   // write side opens wr_phase cycles after reset, shifting its pointer
   // against the read side; the read side waits for rd_margin words
   logic [7:0] phase_cnt;
   wire wr_open = ~in_reset & (phase_cnt == wr_phase); // RULE4

   always_ff @(posedge sys_clk) begin
      if (rst | in_reset) phase_cnt <= 8'h00;
      else if (phase_cnt != wr_phase) phase_cnt <= phase_cnt + 8'h01; // RULE4
   end

////////////////////////////////////////////////////////////////////////////////
// lanes

   wire user_oct = in_data & ~fr_ilas; // RULE24

   for (genvar i = 0; i < 2; i++) begin : g_lane
      logic [7:0] prev_last;
      logic rd_go;
      wire [7:0] oct = fr_data[8*i +: 8];
      wire f_rdy;
      wire [3:0] lvl;
      wire [8:0] f_out;
      wire f_ov;
      wire mf = lane_sync & fr_mf_end[i]; // RULE22
      wire acc = fr_valid[i] & fr_ready[i];
      wire last = user_oct & fr_frame_end[i]; // RULE24
      wire rep_rpt = ~scr_active & (oct == prev_last); // RULE19
      wire rep_d7 = scr_active & ~mf & (oct == `SLA_CHR_28_7); // RULE20 RULE22
      wire rep_d3 = scr_active & mf & (oct == `SLA_CHR_28_3); // RULE21
      wire rep = last & (rep_rpt | rep_d7 | rep_d3);
      // scrambled octets already carry the character value, only k changes
      wire [7:0] oct_o = (rep & rep_rpt) ? (mf ? `SLA_CHR_28_3 : `SLA_CHR_28_7) : oct; // RULE19
      wire lane_wr = fr_valid[i] & lane_on[i] & wr_open;

      assign fr_ready[i] = f_rdy & lane_on[i] & wr_open;

      // comparison uses the original octet, not the replaced one
      always_ff @(posedge sys_clk) begin
         if (rst | in_reset) prev_last <= 8'h00;
         else if (acc & fr_frame_end[i]) prev_last <= oct; // RULE19
      end

      always_ff @(posedge sys_clk) begin
         if (rst | in_reset) rd_go <= 1'b0;
         else if (lvl >= rd_margin[3:0]) rd_go <= 1'b1; // RULE4
      end

      sla_fifo #(
         .WIDTH(9),
         .DEPTH(`SLA_FIFO_DEPTH)
      ) u_fifo (
         .sys_clk(sys_clk),
         .rst(rst),
         .clr(in_reset),
         .in_valid(lane_wr),
         .in_ready(f_rdy),
         .in_data({rep, oct_o}),
         .out_valid(f_ov),
         .out_ready(ser_ready[i] & rd_go),
         .out_data(f_out),
         .level(lvl)
      ); // RULE3

      assign ser_valid[i] = f_ov & rd_go;
      assign ser_data[8*i +: 8] = f_out[7:0];
      assign ser_k[i] = f_out[8];
   end

////////////////////////////////////////////////////////////////////////////////
// register read

   wire [7:0] rd_mux =
      (reg_addr == `SLA_OFS_SYSREF_CFG) ? sysref_cfg :
      (reg_addr == `SLA_OFS_QUICK_CFG) ? quick_cfg :
      (reg_addr == `SLA_OFS_LINK_CTRL) ? link_ctrl :
      (reg_addr == `SLA_OFS_LANE_SCR) ? {scr_en, 6'h00, lanes_m1} :
      (reg_addr == `SLA_OFS_OCT_FRAME) ? par_f :
      (reg_addr == `SLA_OFS_CONV_CNT) ? par_m :
      (reg_addr == `SLA_OFS_SAMP_FRAME) ? {3'h0, par_s} :
      (reg_addr == `SLA_OFS_HD_FLAG) ? {hd_flag, 7'h00} : // RULE6
      (reg_addr == `SLA_OFS_WR_PHASE) ? wr_phase :
      (reg_addr == `SLA_OFS_RD_MARGIN) ? rd_margin :
      (reg_addr == `SLA_OFS_LINK_STAT) ? {4'h0, state} :
      8'h00;

   always_ff @(posedge sys_clk) begin
      if (rst) reg_rdata <= 8'h00;
      else if (reg_re) reg_rdata <= rd_mux;
   end

endmodule : sla_link_ctrl
`default_nettype wire

// ---- testbench/sla_link_ctrl_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module sla_link_ctrl_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_rdata,
   input wire logic sysref,
   input wire logic sync_request_low,
   input wire logic lmfc_tick,
   input wire logic [15:0] ser_data,
   input wire logic [1:0] ser_k,
   input wire logic [1:0] ser_valid,
   input wire logic [1:0] ser_ready,
   input wire logic [1:0] fr_ready,
   input wire logic link_rst,
   input wire logic link_up,
   input wire logic scr_active,
   input wire logic sysref_int,
   input wire logic sysref_capture,
   input wire logic clk_realign
);
   // ticks within the current low stretch, saturating so a long stretch cannot wrap
   logic [2:0] tick_cnt;
   always_ff @(posedge sys_clk) begin
      if (rst || sync_request_low)
         tick_cnt <= 3'h0;
      else if (lmfc_tick && tick_cnt != 3'h7)
         tick_cnt <= tick_cnt + 3'h1;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   sequence s_held_rst;
      ##[0:1] link_rst;
   endsequence
   a_gate_sysref: assert property (sysref_int |-> sysref)
      else $error("gated sysref high without sysref");
   a_capture_edge: assert property (sysref_capture |-> $past(sysref_int) && !$past(sysref_int, 2))
      else $error("capture without gated sysref edge");
   a_realign_resets: assert property (clk_realign |-> s_held_rst)
      else $error("realign without link reset");
   a_sync_four_ticks: assert property (clk_realign && !sysref_capture |-> $past(tick_cnt) >= 3'h4)
      else $error("sync realign before four ticks");
   a_scr_when_up: assert property (scr_active |-> link_up)
      else $error("scrambling outside data state");
   a_rst_closed: assert property (link_rst |-> !link_up && fr_ready == 2'b00)
      else $error("link open while held in reset");
   a_ser_hold: assert property (ser_valid[0] && !ser_ready[0] && !link_rst |=>
      link_rst || ser_valid[0] && $stable(ser_data[7:0]) && $stable(ser_k[0]))
      else $error("serializer word dropped while stalled");
   a_reset_clear: assert property (@(posedge sys_clk) disable iff (1'b0)
      rst |=> link_rst && reg_rdata == 8'h00 && !sysref_capture)
      else $error("reset state wrong");
endmodule : sla_link_ctrl_checker
bind sla_link_ctrl sla_link_ctrl_checker sla_link_ctrl_checker_i (.sys_clk(sys_clk), .rst(rst),
   .reg_rdata(reg_rdata), .sysref(sysref), .sync_request_low(sync_request_low), .lmfc_tick(lmfc_tick),
   .ser_data(ser_data), .ser_k(ser_k), .ser_valid(ser_valid), .ser_ready(ser_ready), .fr_ready(fr_ready),
   .link_rst(link_rst), .link_up(link_up), .scr_active(scr_active), .sysref_int(sysref_int),
   .sysref_capture(sysref_capture), .clk_realign(clk_realign));
`default_nettype wire

// ---- testbench/sla_rx_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sla_rx_model (
   input wire logic sys_clk,
   input wire logic stall,
   input wire logic want_sync,
   input wire logic [15:0] ser_data,
   input wire logic [1:0] ser_k,
   input wire logic [1:0] ser_valid,
   output logic [1:0] ser_ready,
   output logic sync_request_low
);
   // lane 0 words as {k, octet}, in arrival order
   logic [8:0] got[$];
   initial begin
      ser_ready = 2'b11;
      sync_request_low = 1'b1;
   end
   // stall and sync commands take effect one edge late, like a real receiver;
   // sampled on the rising edge so the bench's falling-edge writes never race
   always @(posedge sys_clk) begin
      ser_ready <= {2{!stall}};
      sync_request_low <= !want_sync;
   end
   always @(posedge sys_clk) begin
      if (ser_valid[0] && ser_ready[0])
         got.push_back({ser_k[0], ser_data[7:0]});
   end
endmodule : sla_rx_model
`default_nettype wire

// ---- testbench/sla_link_ctrl_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module sla_link_ctrl_tb_top;
   logic sys_clk, rst, reg_we, reg_re, sysref, lmfc_tick, fr_ilas, stall, want_sync;
   logic sync_request_low, link_rst, link_up, scr_active, sysref_int, sysref_capture, clk_realign;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [15:0] fr_data, ser_data;
   logic [1:0] fr_valid, fr_ready, fr_frame_end, fr_mf_end, ser_k, ser_valid, ser_ready;
   logic [2:0] lm;
   int err_count, tests_run, n_cap, n_ra, n_sri, n_acc;
   // address, value after reset
   logic [15:0] rv [11] = '{16'h3A00, 16'h5E22, 16'h5F10, 16'h6E81, 16'h6F02, 16'h7102, 16'h7401,
      16'h7500, 16'hEE00, 16'hEF02, 16'h0100};
   // setting, then 0x6E, F, M, density; 0x33 must be refused
   logic [39:0] qc [5] = '{40'h1180020100, 40'h1281010180, 40'h2180040200, 40'h3380040200,
      40'h2281020200};
   // scramble reg, link ctrl, octet, multiframe end, word {k, octet}
   logic [39:0] dt [10] = '{40'h8010FC01FC, 40'h8010FC10FC, 40'h80107C117C, 40'h80107C007C,
      40'h0010550055, 40'h00105501FC, 40'h001055117C, 40'h00005511FC, 40'h80007C107C, 40'h8000FC11FC};
   sla_link_ctrl sla_link_ctrl_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .sysref(sysref),
      .sync_request_low(sync_request_low), .lmfc_tick(lmfc_tick), .fr_data(fr_data), .fr_valid(fr_valid),
      .fr_ready(fr_ready), .fr_frame_end(fr_frame_end), .fr_mf_end(fr_mf_end), .fr_ilas(fr_ilas),
      .ser_data(ser_data), .ser_k(ser_k), .ser_valid(ser_valid), .ser_ready(ser_ready), .link_rst(link_rst),
      .link_up(link_up), .scr_active(scr_active), .sysref_int(sysref_int), .sysref_capture(sysref_capture),
      .clk_realign(clk_realign));
   sla_rx_model sla_rx_model_i (.sys_clk(sys_clk), .stall(stall), .want_sync(want_sync), .ser_data(ser_data),
      .ser_k(ser_k), .ser_valid(ser_valid), .ser_ready(ser_ready), .sync_request_low(sync_request_low));
   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   // multiframe tick every 8 cycles
   always @(negedge sys_clk) begin
      lm <= lm + 3'h1;
      lmfc_tick <= (lm == 3'h7);
   end
   always @(posedge sys_clk) begin
      n_cap += sysref_capture;
      n_ra += clk_realign;
      n_sri += sysref_int;
      n_acc += fr_valid[0] & fr_ready[0];
   end
   ////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task cycles(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cycles
   task clr;
      n_cap = 0;
      n_ra = 0;
      n_sri = 0;
      n_acc = 0;
   endtask : clr
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_we = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_we = 0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      reg_re = 1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_re = 0;
      chk("reg_rdata", {1'b0, reg_rdata}, {1'b0, e});
   endtask : rd
   task pulse;
      @(negedge sys_clk);
      sysref = 1;
      @(negedge sys_clk);
      sysref = 0;
      cycles(3);
   endtask : pulse
   task send(input logic [7:0] d, input logic mf);
      int w;
      w = 0;
      @(negedge sys_clk);
      fr_valid = 2'b01;
      fr_data = {8'h00, d};
      fr_frame_end = 2'b01;
      fr_mf_end = {1'b0, mf};
      do begin
         @(posedge sys_clk);
         w++;
      end while (!fr_ready[0] && w < 50);
      @(negedge sys_clk);
      fr_valid = 2'b00;
      fr_data = ~fr_data;
   endtask : send
   task expect_word(input logic [8:0] e);
      int w;
      w = 0;
      while (sla_rx_model_i.got.size() == 0 && w < 40) begin
         @(negedge sys_clk);
         w++;
      end
      chk("ser_word", sla_rx_model_i.got.size() > 0 ? sla_rx_model_i.got.pop_front() : 9'bx, e);
   endtask : expect_word
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////
   initial begin
      #200000;
      err_count++;
      report_and_stop;
   end
   initial begin
      {reg_we, reg_re, sysref, fr_ilas, stall, want_sync, lmfc_tick} = '0;
      {reg_addr, reg_wdata, fr_data, fr_valid, fr_frame_end, fr_mf_end, lm} = '0;
      rst = 1;
      cycles(3);
      rst = 0;
      foreach (rv[i]) rd(rv[i][15:8], rv[i][7:0]);
      wr(8'h5F, 8'h11);
      cycles(2);
      chk("link_rst", 9'(link_rst), 9'h001);
      foreach (qc[i]) begin
         wr(8'h5E, qc[i][39:32]);
         rd(8'h6E, qc[i][31:24]);
         rd(8'h6F, qc[i][23:16]);
         rd(8'h71, qc[i][15:8]);
         rd(8'h74, 8'h01);
         rd(8'h75, qc[i][7:0]);
      end
      wr(8'h6F, 8'h55);
      rd(8'h6F, 8'h02);
      wr(8'hEE, 8'h03);
      wr(8'hEF, 8'hF1);
      rd(8'hEE, 8'h03);
      rd(8'hEF, 8'h01);
      wr(8'h5F, 8'h10);
      cycles(4);
      chk("link_rst", 9'(link_rst), 9'h000);
      // sysref gating, capture, one-shot clear, realign
      clr;
      pulse;
      chk("sysref_int", 9'(n_sri), 9'h000);
      wr(8'h3A, 8'h01);
      clr;
      pulse;
      chk("sysref_int", 9'(n_sri), 9'h001);
      chk("capture", 9'(n_cap), 9'h000);
      wr(8'h3A, 8'h03);
      clr;
      pulse;
      pulse;
      chk("capture", 9'(n_cap), 9'h002);
      chk("realign", 9'(n_ra), 9'h000);
      rd(8'h3A, 8'h03);
      wr(8'h3A, 8'h01);
      wr(8'h3A, 8'h0F);
      clr;
      pulse;
      chk("capture", 9'(n_cap), 9'h001);
      chk("realign", 9'(n_ra), 9'h001);
      rd(8'h3A, 8'h0D);
      clr;
      pulse;
      chk("capture", 9'(n_cap), 9'h000);
      wr(8'h3A, 8'h10);
      clr;
      want_sync = 1;
      cycles(20);
      want_sync = 0;
      cycles(20);
      chk("realign", 9'(n_ra), 9'h000);
      want_sync = 1;
      cycles(44);
      want_sync = 0;
      cycles(10);
      chk("realign", 9'(n_ra), 9'h001);
      wr(8'h3A, 8'h00);
      // bring the link into alignment, then send one octet there
      fr_ilas = 1;
      want_sync = 1;
      cycles(4);
      want_sync = 0;
      cycles(4);
      rd(8'h90, 8'h04);
      send(8'hFC, 1'b0);
      // a repeated frame end inside the alignment sequence must stay data
      send(8'hFC, 1'b0);
      fr_ilas = 0;
      expect_word(9'h0FC);
      expect_word(9'h0FC);
      cycles(2);
      chk("link_up", 9'(link_up), 9'h001);
      chk("scr_active", 9'(scr_active), 9'h001);
      foreach (dt[i]) begin
         wr(8'h6E, dt[i][39:32]);
         wr(8'h5F, dt[i][31:24]);
         send(dt[i][23:16], dt[i][12]);
         expect_word(dt[i][8:0]);
      end
      // fill while the receiver stalls, then drain
      clr;
      stall = 1;
      cycles(2);
      fr_frame_end = 2'b00;
      fr_data = 16'h2211;
      fr_valid = 2'b11;
      cycles(20);
      chk("fr_ready", 9'(fr_ready[0]), 9'h000);
      chk("fr_ready1", 9'(fr_ready[1]), 9'h000);
      chk("accepted", 9'(n_acc), 9'h008);
      chk("ser_valid", 9'(ser_valid), 9'h003);
      chk("ser_lane1", {ser_k[1], ser_data[15:8]}, 9'h022);
      fr_valid = 2'b00;
      stall = 0;
      cycles(20);
      chk("drained", 9'(sla_rx_model_i.got.size()), 9'h008);
      chk("ser_valid", 9'(ser_valid), 9'h000);
      rst = 1;
      cycles(3);
      rst = 0;
      rd(8'h3A, 8'h00);
      rd(8'h6E, 8'h81);
      report_and_stop;
   end
endmodule : sla_link_ctrl_tb_top
`default_nettype wire
